/* File: logic/vcc_changeover.v */
/*
 video changeover controller: input selection (manual or three-slot automatic with
 hold, lock and latch), nine trigger blocks, de-glitcher buffer with frame repeat and
 audio fade, mute/generator fallback and 2x2 output cross point.
 assumes all inputs synchronous to clk_sys_i; detector flags and levels come from
 outside; frame, switching-line and sample strobes are one-cycle pulses.
*/
// Behaviour
// - asynchronous transport mode refuses lock to video without that transport
// - transport mode: stream only checked; output only via pass-through path
// - selected stream goes through de-glitcher before frame store and audio split
// - two outputs each choose pass-through or processed stream independently
// - input chosen manually or by automatic priority mechanism
// - with reference sync present, switch only on the switching line
// - automatic mode has three priority slots: input one, two or generator
// - missing active source advances to next slot and checks it
// - disabled third slot leaves only main and one fallback
// - hold time of absence before advancing, lock time of presence before valid
// - selection latches; return to main by latch reset or fallback loss
// - in transport mode mute and generator give no usable fallback
// - each trigger block has enable, mask, operator, hold time, threshold
// - each trigger block reports all detections regardless of mask or enable
// - enabled block fires after combined error persists for full hold time
// - only masked detections count toward switching
// - or: any selected detection; and: all selected detections together
// - content blocks compare against own threshold; some have none
// - nine blocks: video error, content, four audio, silence, clipping, freeze
// - phase beyond 1024 samples: repeat frame, refill buffer, read centre; pointers not restarted if a sample strobe meets the frame start
// - after re-alignment new phase becomes reference
// - audio fades out during repeat, fades in at new frame
// - on loss of signal processed output routes mute or generator
// - generator: colour bars when selector off, black when on
`timescale 1ns/1ps
`include "vcc_defs.vh"

module vcc_changeover (
   // clock, reset, enable
   input wire clk_sys_i,
   input wire rst_i,
   input wire ce_i,
   // configuration
   input wire auto_mode_i,
   input wire [1:0] manual_src_i,
   input wire [5:0] prio_slots_i,
   input wire asi_mode_i,
   input wire [`VCC_TIME_W-1:0] hold_cycles_i,
   input wire [`VCC_TIME_W-1:0] lock_cycles_i,
   input wire out1_processed_i,
   input wire out2_processed_i,
   input wire use_generator_i,
   input wire gen_black_i,
   input wire latch_reset_n_i,
   input wire latch_set_n_i,
   // trigger block configuration, flat per block
   input wire [`VCC_NTRIG-1:0] trig_enable_i,
   input wire [`VCC_NTRIG*`VCC_TDET-1:0] trig_mask_i,
   input wire [`VCC_NTRIG-1:0] trig_and_i,
   input wire [`VCC_NTRIG*`VCC_TIME_W-1:0] trig_hold_i,
   input wire [`VCC_NTRIG*`VCC_THR_W-1:0] trig_thresh_i,
   input wire [`VCC_NTRIG-1:0] trig_has_thresh_i,
   input wire [`VCC_NTRIG*`VCC_THR_W-1:0] trig_level_i,
   input wire [`VCC_NTRIG*`VCC_TDET-1:0] trig_det_i,
   // input status
   input wire in1_present_i,
   input wire in2_present_i,
   input wire in1_is_asi_i,
   input wire in2_is_asi_i,
   input wire sync_present_i,
   input wire switch_line_i,
   // stream
   input wire [`VCC_DATA_W-1:0] in1_data_i,
   input wire [`VCC_DATA_W-1:0] in2_data_i,
   input wire sample_stb_i,
   input wire frame_start_i,
   input wire [`VCC_ADDR_W:0] in_phase_i,
   input wire [`VCC_DATA_W-1:0] proc_data_i,
   // outputs
   output reg [1:0] active_src_o,
   output reg latched_o,
   output reg los_o,
   output wire [`VCC_NTRIG*`VCC_TDET-1:0] trig_status_o,
   output reg [`VCC_NTRIG-1:0] trig_fired_o,
   output reg [`VCC_DATA_W-1:0] dg_data_o,
   output reg frame_repeat_o,
   output reg [`VCC_FADE_W-1:0] audio_gain_o,
   output reg [`VCC_DATA_W-1:0] proc_out_o,
   output reg [`VCC_DATA_W-1:0] out1_data_o,
   output reg [`VCC_DATA_W-1:0] out2_data_o,
   output reg out1_valid_o,
   output reg out2_valid_o
);

   localparam ST_PRIO0 = 2'h0;
   localparam ST_PRIO1 = 2'h1;
   localparam ST_PRIO2 = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // source validity with hold and lock timers
   reg [1:0] valid;
   reg [`VCC_TIME_W-1:0] vcnt0;
   reg [`VCC_TIME_W-1:0] vcnt1;
   wire [1:0] raw_ok;
   // transport mode refuses plain video streams
   assign raw_ok[0] = in1_present_i & (~asi_mode_i | in1_is_asi_i);
   assign raw_ok[1] = in2_present_i & (~asi_mode_i | in2_is_asi_i);

   // count disagreement; flip only after the hold or lock span elapses
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         valid <= 2'h0;
         vcnt0 <= {`VCC_TIME_W{1'b0}};
         vcnt1 <= {`VCC_TIME_W{1'b0}};
      end else if (ce_i) begin
         if (raw_ok[0] == valid[0]) begin
            vcnt0 <= {`VCC_TIME_W{1'b0}};
         end else if (vcnt0 + 1'b1 >= (valid[0] ? hold_cycles_i : lock_cycles_i)) begin
            valid[0] <= raw_ok[0];
            vcnt0 <= {`VCC_TIME_W{1'b0}};
         end else begin
            vcnt0 <= vcnt0 + 1'b1;
         end
         if (raw_ok[1] == valid[1]) begin
            vcnt1 <= {`VCC_TIME_W{1'b0}};
         end else if (vcnt1 + 1'b1 >= (valid[1] ? hold_cycles_i : lock_cycles_i)) begin
            valid[1] <= raw_ok[1];
            vcnt1 <= {`VCC_TIME_W{1'b0}};
         end else begin
            vcnt1 <= vcnt1 + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // trigger blocks, one per generate entry
   genvar g;
   generate
      for (g = 0; g < `VCC_NTRIG; g = g + 1) begin : trig_blk
         wire [`VCC_TDET-1:0] det = trig_det_i[g*`VCC_TDET +: `VCC_TDET];
         wire [`VCC_TDET-1:0] msk = trig_mask_i[g*`VCC_TDET +: `VCC_TDET];
         // threshold check occupies bit 0 where the block has one
         wire over = trig_has_thresh_i[g] &
            (trig_level_i[g*`VCC_THR_W +: `VCC_THR_W] >= trig_thresh_i[g*`VCC_THR_W +: `VCC_THR_W]);
         wire [`VCC_TDET-1:0] all_det = {det[`VCC_TDET-1:1], det[0] | over};
         wire cond_or = |(all_det & msk);
         wire cond_and = (|msk) & ((all_det & msk) == msk);
         wire cond = trig_and_i[g] ? cond_and : cond_or;
         reg [`VCC_TIME_W-1:0] cnt;
         assign trig_status_o[g*`VCC_TDET +: `VCC_TDET] = all_det;
         // continuous presence for the full hold time, then fire until condition clears
         always @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               cnt <= {`VCC_TIME_W{1'b0}};
               trig_fired_o[g] <= 1'b0;
            end else if (ce_i) begin
               if (!(cond & trig_enable_i[g])) begin
                  cnt <= {`VCC_TIME_W{1'b0}};
                  trig_fired_o[g] <= 1'b0;
               end else if (cnt + 1'b1 >= trig_hold_i[g*`VCC_TIME_W +: `VCC_TIME_W]) begin
                  trig_fired_o[g] <= 1'b1;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // priority selection
   reg [1:0] prio;
   reg [1:0] next_prio;
   reg next_latched;
   wire any_fire = |trig_fired_o;
   wire [1:0] slot0 = prio_slots_i[1:0];
   wire [1:0] slot1 = prio_slots_i[3:2];
   wire [1:0] slot2 = prio_slots_i[5:4];
   wire [1:0] cur_slot = (prio == ST_PRIO0) ? slot0 : (prio == ST_PRIO1) ? slot1 : slot2;
   wire [1:0] step_slot = (prio == ST_PRIO0) ? ST_PRIO1 : ST_PRIO2;

   // source usable: generator never counts as a fallback in transport mode
   function src_ok;
      input [1:0] s;
      begin
         src_ok = (s == `VCC_SRC_IN1) ? valid[0] :
                  (s == `VCC_SRC_IN2) ? valid[1] :
                  (s == `VCC_SRC_GEN) ? ~asi_mode_i : 1'b0;
      end
   endfunction

   // changes wait for the switching line only when a reference is present
   wire switch_ok = ~sync_present_i | switch_line_i;
   wire cur_lost = ~src_ok(cur_slot) | any_fire;

   always @* begin
      next_prio = prio;
      next_latched = latched_o;
      case (prio)
         ST_PRIO0: begin
            if (cur_lost) begin
               next_prio = ST_PRIO1;
               next_latched = 1'b1;
            end
         end
         ST_PRIO1: begin
            // disabled third slot falls straight back to main
            if (cur_lost) begin
               next_prio = (slot2 == `VCC_SRC_OFF) ? ST_PRIO0 : ST_PRIO2;
            end
         end
         ST_PRIO2: begin
            if (cur_lost) begin
               next_prio = ST_PRIO0;
            end
         end
         default: begin
            next_prio = ST_PRIO0;
         end
      endcase
      if (!latch_set_n_i) begin
         next_prio = ST_PRIO1;
         next_latched = 1'b1;
      end
      if (!latch_reset_n_i) begin
         next_prio = ST_PRIO0;
         next_latched = 1'b0;
      end
      if (next_prio == ST_PRIO0 && latch_reset_n_i && latch_set_n_i) begin
         next_latched = 1'b0;
      end
   end

   // a manual choice bypasses the priority machine
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         prio <= ST_PRIO0;
         latched_o <= 1'b0;
         active_src_o <= `VCC_SRC_IN1;
         los_o <= 1'b1;
      end else if (ce_i && switch_ok) begin
         if (auto_mode_i) begin
            prio <= next_prio;
            latched_o <= next_latched;
            active_src_o <= (next_prio == ST_PRIO0) ? slot0 : (next_prio == ST_PRIO1) ? slot1 : slot2;
         end else begin
            active_src_o <= manual_src_i;
         end
         los_o <= ~src_ok(active_src_o) | (active_src_o == `VCC_SRC_GEN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // de-glitcher: write every sample, read at a fixed offset from reference phase
   reg [`VCC_DATA_W-1:0] dg_mem [0:`VCC_BUF_DEPTH-1];
   reg [`VCC_ADDR_W-1:0] wr_ptr;
   reg [`VCC_ADDR_W-1:0] rd_ptr;
   reg [`VCC_ADDR_W:0] ref_phase;
   reg realign_pend;
   wire [`VCC_DATA_W-1:0] sel_data = (active_src_o == `VCC_SRC_IN2) ? in2_data_i : in1_data_i;
   wire [`VCC_ADDR_W:0] phase_diff = in_phase_i - ref_phase;
   wire neg = phase_diff[`VCC_ADDR_W];
   wire [`VCC_ADDR_W:0] mag = neg ? (~phase_diff + 1'b1) : phase_diff;
   wire too_far = mag > {1'b0, `VCC_PHASE_LIM};

   always @(posedge clk_sys_i) begin
      if (ce_i && sample_stb_i) begin
         dg_mem[wr_ptr] <= sel_data;
      end
   end

   // on excess phase: repeat frame, restart centred unless a sample strobe lands on the frame start, adopt new reference
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= {`VCC_ADDR_W{1'b0}};
         rd_ptr <= {`VCC_ADDR_W{1'b0}};
         ref_phase <= {(`VCC_ADDR_W+1){1'b0}};
         realign_pend <= 1'b0;
         frame_repeat_o <= 1'b0;
         dg_data_o <= {`VCC_DATA_W{1'b0}};
      end else if (ce_i) begin
         if (too_far) begin
            realign_pend <= 1'b1;
         end
         if (frame_start_i) begin
            frame_repeat_o <= realign_pend | too_far;
            if (realign_pend | too_far) begin
               ref_phase <= in_phase_i;
               realign_pend <= 1'b0;
               wr_ptr <= `VCC_BUF_CENTRE;
               rd_ptr <= {`VCC_ADDR_W{1'b0}};
            end
         end
         if (sample_stb_i) begin
            wr_ptr <= wr_ptr + 1'b1;
            rd_ptr <= rd_ptr + 1'b1;
            // repeating frame holds the last seamless sample stream
            if (!frame_repeat_o) begin
               dg_data_o <= dg_mem[rd_ptr];
            end
         end
      end
   end

   // audio fade ramp: down during repeat, up again in the new frame
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         audio_gain_o <= `VCC_FADE_FULL;
      end else if (ce_i && sample_stb_i) begin
         if (frame_repeat_o | realign_pend) begin
            audio_gain_o <= (audio_gain_o == {`VCC_FADE_W{1'b0}}) ? audio_gain_o : audio_gain_o - 1'b1;
         end else if (audio_gain_o != `VCC_FADE_FULL) begin
            audio_gain_o <= audio_gain_o + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // processed path fallback and output cross point
   wire [`VCC_DATA_W-1:0] gen_data = gen_black_i ? 20'h04040 :
      {wr_ptr[`VCC_ADDR_W-1:`VCC_ADDR_W-3], 7'h00, wr_ptr[`VCC_ADDR_W-1:`VCC_ADDR_W-3], 7'h00};
   wire [`VCC_DATA_W-1:0] pass_data = sel_data;

   // registered outputs; transport mode has no processed output
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         proc_out_o <= {`VCC_DATA_W{1'b0}};
         out1_data_o <= {`VCC_DATA_W{1'b0}};
         out2_data_o <= {`VCC_DATA_W{1'b0}};
         out1_valid_o <= 1'b0;
         out2_valid_o <= 1'b0;
      end else if (ce_i) begin
         proc_out_o <= los_o ? (use_generator_i ? gen_data : {`VCC_DATA_W{1'b0}}) : proc_data_i;
         out1_data_o <= out1_processed_i ? proc_out_o : pass_data;
         out2_data_o <= out2_processed_i ? proc_out_o : pass_data;
         out1_valid_o <= ~(asi_mode_i & out1_processed_i);
         out2_valid_o <= ~(asi_mode_i & out2_processed_i);
      end
   end

endmodule // vcc_changeover

/* File: common/vcc_defs.vh */
/*
 constants for the video changeover controller: selector codes, trigger block
 layout, de-glitcher buffer geometry and timer widths.
 assumes it is included by bare name from the design file.
*/
`ifndef VCC_DEFS_VH
`define VCC_DEFS_VH

// source codes for priority slots and the active selection
`define VCC_SRC_IN1 2'h0
`define VCC_SRC_IN2 2'h1
`define VCC_SRC_GEN 2'h2
`define VCC_SRC_OFF 2'h3

// trigger blocks: video error, video content, audio groups 1-4, in silence, out clip, freeze+silence
`define VCC_NTRIG 9
`define VCC_TDET 16
`define VCC_THR_W 16
`define VCC_TIME_W 32

// de-glitcher geometry
`define VCC_BUF_DEPTH 2048
`define VCC_ADDR_W 11
`define VCC_PHASE_LIM 11'h400
`define VCC_BUF_CENTRE 11'h400
`define VCC_DATA_W 20

// audio fade ramp
`define VCC_FADE_W 8
`define VCC_FADE_FULL 8'hFF

`endif

/* File: tb/vcc_src_model.sv */
/*
 far-side model: two serial sources with presence, transport format flag and a
 counting sample stream. assumes one clock shared with the controller.
*/
`timescale 1ns/1ps
module vcc_src_model (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // bench control
   input wire [1:0] link_up_i,
   input wire [1:0] asi_fmt_i,
   // source side
   output reg [1:0] present_o,
   output wire [1:0] is_asi_o,
   output reg [19:0] in1_data_o,
   output reg [19:0] in2_data_o,
   output reg sample_stb_o,
   output wire frame_start_o,
   output wire [11:0] in_phase_o
);
   reg [5:0] cnt;
   // a lost source flags no format; phase held steady
   assign is_asi_o = asi_fmt_i & present_o;
   assign frame_start_o = (cnt == 6'h3F);
   assign in_phase_o = 12'h000;
   // lost links show inverted data so stale values never pass as live
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 6'h00;
         present_o <= 2'h0;
         sample_stb_o <= 1'b0;
         in1_data_o <= 20'h00000;
         in2_data_o <= 20'h00000;
      end else begin
         cnt <= cnt + 6'h01;
         present_o <= link_up_i;
         sample_stb_o <= ~sample_stb_o;
         in1_data_o <= present_o[0] ? {14'h0000, cnt} : ~in1_data_o;
         in2_data_o <= present_o[1] ? {14'h0001, cnt} : ~in2_data_o;
      end
   end
endmodule // vcc_src_model

/* File: tb/vcc_changeover_monitor.sv */
/*
 checker for selection, latch, trigger and transport relations.
 assumes it is bound onto vcc_changeover and sees its ports only.
*/
`timescale 1ns/1ps
`include "vcc_defs.vh"
module vcc_monitor (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   input wire ce_i,
   // configuration
   input wire auto_mode_i,
   input wire [1:0] manual_src_i,
   input wire asi_mode_i,
   input wire out1_processed_i,
   input wire latch_reset_n_i,
   input wire sync_present_i,
   input wire switch_line_i,
   // triggers
   input wire [`VCC_NTRIG-1:0] trig_enable_i,
   input wire [`VCC_NTRIG*`VCC_TDET-1:0] trig_mask_i,
   input wire [`VCC_NTRIG-1:0] trig_and_i,
   input wire [`VCC_NTRIG*`VCC_TIME_W-1:0] trig_hold_i,
   input wire [`VCC_NTRIG-1:0] trig_has_thresh_i,
   input wire [`VCC_NTRIG*`VCC_TDET-1:0] trig_det_i,
   // outputs
   input wire [1:0] active_src_o,
   input wire latched_o,
   input wire los_o,
   input wire [`VCC_NTRIG*`VCC_TDET-1:0] trig_status_o,
   input wire [`VCC_NTRIG-1:0] trig_fired_o,
   input wire out1_valid_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // or-combined condition of block 0
   wire cond0 = trig_enable_i[0] && |(trig_det_i[15:0] & trig_mask_i[15:0]);
   ////////////////////////////////////////////////////////////////////////
   a_manual_pick: assert property ((ce_i && !auto_mode_i && !sync_present_i && !asi_mode_i && manual_src_i != 2'h3
      && $stable(manual_src_i))[*3] |-> active_src_o == manual_src_i)
      else $error("manual source not followed");
   a_switch_line: assert property (ce_i && sync_present_i && !switch_line_i |=> $stable(active_src_o))
      else $error("selection moved off the switching line");
   a_ce_freeze: assert property (!ce_i |=> $stable(active_src_o) && $stable(latched_o) && $stable(trig_fired_o))
      else $error("state moved with clock enable low");
   a_latch_clear: assert property ((ce_i && !latch_reset_n_i && !sync_present_i)[*3] |-> !latched_o)
      else $error("latch not cleared by latch reset");
   a_status_raw: assert property (trig_has_thresh_i == 9'h000 |-> trig_status_o == trig_det_i)
      else $error("trigger status differs from detections");
   a_trig_enable: assert property ((ce_i && !trig_enable_i[0])[*2] |-> !trig_fired_o[0])
      else $error("disabled trigger block fired");
   a_trig_hold: assert property ($rose(trig_fired_o[0]) && !trig_and_i[0] && trig_hold_i[31:0] > 32'h1
      |-> $past(cond0) && $past(cond0, 2))
      else $error("trigger fired without held masked condition");
   a_asi_proc: assert property ((ce_i && asi_mode_i && out1_processed_i)[*2] |-> !out1_valid_o)
      else $error("processed output valid in transport mode");
   a_gen_los: assert property ((ce_i && active_src_o == `VCC_SRC_GEN)[*2] |-> los_o)
      else $error("generator selection without loss flag");
   // main scenarios
   c_fired: cover property ($rose(trig_fired_o[0]));
   c_latched: cover property ($rose(latched_o));
   c_switch: cover property (sync_present_i && switch_line_i ##1 $changed(active_src_o));
endmodule // vcc_monitor
bind vcc_changeover vcc_monitor mon_u (.clk_sys_i, .rst_i, .ce_i, .auto_mode_i, .manual_src_i, .asi_mode_i,
   .out1_processed_i, .latch_reset_n_i, .sync_present_i, .switch_line_i, .trig_enable_i, .trig_mask_i,
   .trig_and_i, .trig_hold_i, .trig_has_thresh_i, .trig_det_i, .active_src_o, .latched_o, .los_o,
   .trig_status_o, .trig_fired_o, .out1_valid_o);

/* File: tb/vcc_changeover_bench.sv */
/*
 self-checking bench for the changeover controller: manual, sync-gated,
 automatic, latch, trigger and transport-mode sequences.
 assumes the source model and bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "vcc_defs.vh"
module vcc_changeover_bench;
   reg clk_sys_i, rst_i, ce_i, auto_mode_i, asi_mode_i, out1_processed_i, sync_present_i, switch_line_i;
   reg latch_reset_n_i, latch_set_n_i, use_generator_i;
   reg [1:0] manual_src_i, link_up, asi_fmt;
   reg [5:0] prio_slots_i;
   reg [8:0] trig_enable_i, trig_and_i;
   reg [143:0] trig_mask_i, trig_det_i;
   reg [287:0] trig_hold_i;
   wire [1:0] present, is_asi, active_src_o;
   wire [19:0] in1_data, in2_data;
   wire sample_stb, frame_start, latched_o, los_o, out1_valid_o;
   wire [11:0] in_phase;
   wire [8:0] trig_fired_o;
   wire [143:0] trig_status_o;
   integer miscompares, tests_run, cycles;
   ////////////////////////////////////////////////////////////////////////
   // free-running 250 MHz clock and cycle ceiling
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         stop_test;
      end
   end
   vcc_src_model src_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link_up_i(link_up), .asi_fmt_i(asi_fmt),
      .present_o(present), .is_asi_o(is_asi), .in1_data_o(in1_data), .in2_data_o(in2_data),
      .sample_stb_o(sample_stb), .frame_start_o(frame_start), .in_phase_o(in_phase));
   vcc_changeover dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .auto_mode_i(auto_mode_i),
      .manual_src_i(manual_src_i), .prio_slots_i(prio_slots_i), .asi_mode_i(asi_mode_i),
      .hold_cycles_i(32'h4), .lock_cycles_i(32'h4), .out1_processed_i(out1_processed_i),
      .out2_processed_i(out1_processed_i), .use_generator_i(use_generator_i), .gen_black_i(asi_mode_i),
      .latch_reset_n_i(latch_reset_n_i), .latch_set_n_i(latch_set_n_i), .trig_enable_i(trig_enable_i),
      .trig_mask_i(trig_mask_i), .trig_and_i(trig_and_i), .trig_hold_i(trig_hold_i), .trig_thresh_i(144'h0),
      .trig_has_thresh_i(9'h000), .trig_level_i(144'h0), .trig_det_i(trig_det_i), .in1_present_i(present[0]),
      .in2_present_i(present[1]), .in1_is_asi_i(is_asi[0]), .in2_is_asi_i(is_asi[1]),
      .sync_present_i(sync_present_i), .switch_line_i(switch_line_i), .in1_data_i(in1_data),
      .in2_data_i(in2_data), .sample_stb_i(sample_stb), .frame_start_i(frame_start), .in_phase_i(in_phase),
      .proc_data_i(in2_data), .active_src_o(active_src_o), .latched_o(latched_o), .los_o(los_o),
      .trig_status_o(trig_status_o), .trig_fired_o(trig_fired_o), .dg_data_o(), .frame_repeat_o(),
      .audio_gain_o(), .proc_out_o(), .out1_data_o(), .out2_data_o(), .out1_valid_o(out1_valid_o),
      .out2_valid_o());
   ////////////////////////////////////////////////////////////////////////
   task check_src(input [1:0] exp);
      begin
         tests_run = tests_run + 1;
         if (active_src_o !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: source %0d expected %0d", $time, active_src_o, exp);
         end
      end
   endtask
   task check_bit(input got, input exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
         end
      end
   endtask
   // bounded wait; the compare afterwards reports a miss
   task wait_src(input [1:0] exp);
      integer n;
      begin
         n = 0;
         while (active_src_o !== exp && n < 60) begin
            @(posedge clk_sys_i);
            n = n + 1;
         end
         check_src(exp);
      end
   endtask
   task ticks(input integer n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // strobe held three cycles so a one-cycle sample cannot miss it
   task pulse_latch(input reset_side);
      begin
         @(posedge clk_sys_i);
         if (reset_side) latch_reset_n_i <= 1'b0; else latch_set_n_i <= 1'b0;
         ticks(3);
         latch_reset_n_i <= 1'b1;
         latch_set_n_i <= 1'b1;
      end
   endtask
   task stop_test;
      begin
         if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      miscompares = 0; tests_run = 0; cycles = 0;
      rst_i = 1'b1; ce_i = 1'b1; auto_mode_i = 1'b0; asi_mode_i = 1'b0; out1_processed_i = 1'b0;
      sync_present_i = 1'b0; switch_line_i = 1'b0; latch_reset_n_i = 1'b1; latch_set_n_i = 1'b1;
      use_generator_i = 1'b1;
      manual_src_i = `VCC_SRC_IN1; link_up = 2'b11; asi_fmt = 2'b00;
      prio_slots_i = {`VCC_SRC_OFF, `VCC_SRC_IN2, `VCC_SRC_IN1};
      trig_enable_i = 9'h000; trig_and_i = 9'h000; trig_mask_i = 144'h0; trig_det_i = 144'h0;
      trig_hold_i = 288'h5;
      ticks(12);
      rst_i <= 1'b0;
      @(posedge clk_sys_i) manual_src_i <= `VCC_SRC_IN2;
      wait_src(`VCC_SRC_IN2);
      @(posedge clk_sys_i) sync_present_i <= 1'b1;
      manual_src_i <= `VCC_SRC_IN1;
      ticks(8);
      check_src(`VCC_SRC_IN2);
      switch_line_i <= 1'b1;
      @(posedge clk_sys_i) switch_line_i <= 1'b0;
      ticks(3);
      check_src(`VCC_SRC_IN1);
      sync_present_i <= 1'b0;
      auto_mode_i <= 1'b1;
      pulse_latch(1'b1);
      wait_src(`VCC_SRC_IN1);
      link_up <= 2'b10;
      ticks(3);
      check_src(`VCC_SRC_IN1);
      wait_src(`VCC_SRC_IN2);
      check_bit(latched_o, 1'b1);
      link_up <= 2'b11;
      ticks(20);
      check_src(`VCC_SRC_IN2);
      pulse_latch(1'b1);
      wait_src(`VCC_SRC_IN1);
      check_bit(latched_o, 1'b0);
      pulse_latch(1'b0);
      wait_src(`VCC_SRC_IN2);
      pulse_latch(1'b1);
      wait_src(`VCC_SRC_IN1);
      // trigger block 0: unmasked detection, then and, then or
      trig_enable_i <= 9'h001;
      trig_mask_i[15:0] <= 16'h0001;
      trig_det_i[15:0] <= 16'h0002;
      ticks(12);
      check_bit(trig_fired_o[0], 1'b0);
      check_bit(trig_status_o[1], 1'b1);
      trig_and_i <= 9'h001;
      trig_mask_i[15:0] <= 16'h0003;
      trig_det_i[15:0] <= 16'h0001;
      ticks(12);
      check_bit(trig_fired_o[0], 1'b0);
      trig_and_i <= 9'h000;
      ticks(3);
      check_bit(trig_fired_o[0], 1'b0);
      ticks(6);
      check_bit(trig_fired_o[0], 1'b1);
      wait_src(`VCC_SRC_IN2);
      trig_det_i[15:0] <= 16'h0000;
      pulse_latch(1'b1);
      wait_src(`VCC_SRC_IN1);
      // transport mode with non-transport sources, then with transport sources
      asi_mode_i <= 1'b1;
      out1_processed_i <= 1'b1;
      ticks(20);
      check_bit(out1_valid_o, 1'b0);
      check_bit(los_o, 1'b1);
      out1_processed_i <= 1'b0;
      asi_fmt <= 2'b11;
      ticks(30);
      check_bit(out1_valid_o, 1'b1);
      stop_test;
   end
endmodule // vcc_changeover_bench
